// ### src/oss_cfg.svh
// offsets, field positions, reset values and timing counts for sample sync control
//
// Summary of operation
// - power_save_request enters power save, registers kept
// - power save clears flags, stops oscillator
// - results keep last completed conversion in power save
// - power save request aborts running conversion
// - reset bit returns all registers to reset
// - reset bit self-clears after reset sequence
// - timestamp pushed every eight samples when enabled
// - changed subranging code replaces tag with 0x1D
// - software restart aborts sample, starts new, self-clears
// - mode 0000 drives pin only on A/B/C
// - mode 0010: pin starts samples, internal exposures
// - mode 0110: pin times samples and exposures
// - mode 1001: falling edge terminates current sample
// - mode 1010: edge wakes one sample, then sleep
// - dark offset added when enabled
// - offset 8192 single pulse, 4096 dual pulse
// - range select sets converter step size; this block has no range select field and drives no step size
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OSS_IDX_STAT     8'h00
`define OSS_IDX_RES      8'h01
`define OSS_IDX_SYS      8'h0D
`define OSS_IDX_SYNC     8'h10
`define OSS_IDX_CFG1     8'h11
`define OSS_IDX_CFG2     8'h12

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define OSS_SYS_RST      8'h00
`define OSS_SYS_MASK     8'h0E
`define OSS_SYNC_RST     8'h00
`define OSS_SYNC_MASK    8'hCF
`define OSS_CFG1_RST     8'h03
`define OSS_CFG1_MASK    8'hCF
`define OSS_CFG2_RST     8'h88

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OSS_SYS_RESET    0
`define OSS_SYS_PSAVE    1
`define OSS_SYNC_TSEN    7
`define OSS_SYNC_CHG     6
`define OSS_SYNC_SWR     4
`define OSS_CFG1_DOFF    6

// ----------------------------------------------------------------
// pin function codes, tags, offsets
// ----------------------------------------------------------------
`define OSS_PIN_MUX      4'h0
`define OSS_PIN_STRIG    4'h2
`define OSS_PIN_XTRIG    4'h6
`define OSS_PIN_ABORT    4'h9
`define OSS_PIN_WAKE     4'hA
`define OSS_TAG_CHG      5'h1D
`define OSS_TAG_TS       5'h1E
`define OSS_OFS_SINGLE   20'h02000
`define OSS_OFS_DUAL     20'h01000
`define OSS_SR_DUAL_LO   5'h06
`define OSS_SR_DUAL_HI   5'h09
`define OSS_DATA_MAX     19'h7FFFF

// ----------------------------------------------------------------
// timing: figures in ns, counts at the 8 ns clock, least times round up
// ----------------------------------------------------------------
`define OSS_CLK_NS       8
`define OSS_NS2CYC(ns)   (((ns) + `OSS_CLK_NS - 1) / `OSS_CLK_NS)
`define OSS_POR_NS       1000
`define OSS_POR_CYC      `OSS_NS2CYC(`OSS_POR_NS)
`define OSS_PW0_NS       21300
`define OSS_PW1_NS       35900
`define OSS_PW2_NS       65200
`define OSS_PW3_NS       123800
`define OSS_SMP_PER_NS   40008002

`endif

// ### src/oss_pkg.sv
// types shared by the sample sync control block
package oss_pkg;
  // exposure sequencer states
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_EXPOSE,
    SQ_GAP
  } oss_seq_state_t;
  // converter sample word
  typedef logic [18:0] oss_data_t;
endpackage

// ### src/oss_seq.sv
// exposure sequencer: runs the exposures of one sample
`timescale 1ns/100ps
`default_nettype none
module oss_seq #(
  parameter int CW = 16,
  parameter int XW = 3
) (
  input  wire logic          aclk,
  input  wire logic          srst_n,
  input  wire logic          start,
  input  wire logic          abort,
  input  wire logic          ext_step_mode,
  input  wire logic          step,
  input  wire logic [XW-1:0] n_exp,
  input  wire logic [CW-1:0] pw_cyc,
  output logic               busy,
  output logic               exp_done,
  output logic [XW-1:0]      exp_idx,
  output logic               smp_done
);
  oss_pkg::oss_seq_state_t st_q;  // sequencer state
  logic [CW-1:0]           cnt_q;  // cycles into exposure
  logic [XW-1:0]           idx_q;  // running exposure slot

  assign busy = (st_q != oss_pkg::SQ_IDLE);

  // ----------------------------------------------------------------
  // sequence: start restarts from any state, so a restart needs no idle gap
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!srst_n) begin
      st_q     <= oss_pkg::SQ_IDLE;
      cnt_q    <= '0;
      idx_q    <= '0;
      exp_done <= 1'b0;
      exp_idx  <= '0;
      smp_done <= 1'b0;
    end else begin
      exp_done <= 1'b0;
      smp_done <= 1'b0;
      if (start) begin
        st_q  <= oss_pkg::SQ_EXPOSE;
        cnt_q <= '0;
        idx_q <= '0;
      end else if (abort) begin
        // abandoned sample: no done pulses
        st_q <= oss_pkg::SQ_IDLE;
      end else begin
        case (st_q)
          oss_pkg::SQ_EXPOSE: begin
            if (cnt_q == pw_cyc - 1'b1) begin
              exp_done <= 1'b1;
              exp_idx  <= idx_q;
              cnt_q    <= '0;
              if (idx_q == n_exp - 1'b1) begin
                smp_done <= 1'b1;
                st_q     <= oss_pkg::SQ_IDLE;
              end else begin
                idx_q <= idx_q + 1'b1;
                // external mode waits for the next pin edge
                st_q  <= ext_step_mode ? oss_pkg::SQ_GAP : oss_pkg::SQ_EXPOSE;
              end
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          oss_pkg::SQ_GAP: begin
            if (step) begin
              st_q <= oss_pkg::SQ_EXPOSE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### src/oss_top.sv
// sample sync control: register slave, pin trigger modes, tagging and power save
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "oss_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module oss_top #(
  parameter int          ADDR_W     = 12,
  parameter int          NUM_SLOTS  = 2,
  parameter int unsigned PW2_CYC    = `OSS_NS2CYC(`OSS_PW2_NS),
  parameter int unsigned PW3_CYC    = `OSS_NS2CYC(`OSS_PW3_NS),
  parameter int unsigned SMP_PER_CYC = `OSS_NS2CYC(`OSS_SMP_PER_NS)
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              gpio_in,
  output logic                   gpio_out,
  output logic                   gpio_oe,
  input  wire logic              slot_abc_active,
  input  wire logic [18:0]       adc_data,
  input  wire logic              dac_code_changed,
  output logic                   osc_run,
  output logic                   push_valid,
  output logic [4:0]             push_tag,
  output logic [18:0]            push_data
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              por_q;      // forced reset sequence running
  logic [15:0]       por_cnt_q;  // reset sequence timer
  logic [7:0]        sys_q;      // system control storage
  logic [7:0]        sync_q;     // sample sync control storage
  logic              swr_q;      // software restart pulse
  logic [7:0]        cfg1_q;     // readout config one
  logic [7:0]        cfg2_q;     // rate and averaging
  logic              rdy_q;      // sample ready flag
  logic              aw_full_q;  // write address held
  logic              w_full_q;   // write data held
  logic [7:0]        aw_idx_q;   // held write index
  logic              aw_ok_q;    // held address word aligned
  logic [7:0]        w_byte_q;   // held write byte
  logic              w_lane_q;   // byte lane 0 enabled
  logic              gpio_prev_q; // pin sampled last cycle
  logic [31:0]       fr_cnt_q;   // free-run sample timer
  logic              awake_q;    // single sample wake in progress
  logic              ts_pend_q;  // timestamp push owed
  logic [2:0]        smp_cnt_q;  // samples in timestamp block
  logic [18:0]       ts_cnt_q;   // completed sample count
  oss_pkg::oss_data_t last_res_q; // last completed result

  logic              rst_n;
  logic              do_wr;
  logic              aw_take;
  logic              ar_take;
  logic              w_hit;
  logic [7:0]        ar_idx;
  logic              psave;
  logic [3:0]        mode;
  logic              fall;
  logic              busy;
  logic              exp_done;
  logic              smp_done;
  logic [2:0]        exp_idx;
  logic              start;
  logic              abort;
  logic              fr_tick;
  logic              dual;
  logic [15:0]       pw_cyc;
  logic [19:0]       sum;
  oss_pkg::oss_data_t sat;

  // forced reset holds everything but the bus slave
  assign rst_n = aresetn & ~por_q;
  assign psave = sys_q[`OSS_SYS_PSAVE];
  assign mode  = sync_q[3:0];
  assign fall  = gpio_prev_q & ~gpio_in;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign aw_take = awvalid & awready;
  assign ar_take = arvalid & arready;
  assign do_wr   = aw_full_q & w_full_q & ~bvalid;
  assign ar_idx  = araddr[9:2];
  assign w_hit   = do_wr & aw_ok_q & w_lane_q;

  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_idx_q  <= 8'h00;
      aw_ok_q   <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
    end else begin
      aw_full_q <= (aw_full_q & ~do_wr) | aw_take;
      w_full_q  <= (w_full_q & ~do_wr) | (wvalid & wready);
      awready   <= ~((aw_full_q & ~do_wr) | aw_take);
      wready    <= ~((w_full_q & ~do_wr) | (wvalid & wready));
      if (aw_take) begin
        aw_idx_q <= awaddr[9:2];
        aw_ok_q  <= (awaddr[1:0] == 2'h0) && (awaddr[ADDR_W-1:10] == '0);
      end
      if (wvalid & wready) begin
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        // unmapped or misaligned addresses answer slave error
        bresp  <= (aw_ok_q && (aw_idx_q == `OSS_IDX_SYS || aw_idx_q == `OSS_IDX_SYNC
                   || aw_idx_q == `OSS_IDX_CFG1 || aw_idx_q == `OSS_IDX_CFG2)) ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
    end else begin
      arready <= ~(ar_take | (rvalid & ~rready));
      if (ar_take) begin
        rvalid <= 1'b1;
        rresp  <= 2'h0;
        case (ar_idx)
          `OSS_IDX_STAT: rdata <= {28'h0, awake_q, osc_run, busy, rdy_q};
          `OSS_IDX_RES:  rdata <= {13'h0, last_res_q};
          `OSS_IDX_SYS:  rdata <= {24'h0, sys_q[7:1], por_q};
          `OSS_IDX_SYNC: rdata <= {24'h0, sync_q[7:5], swr_q, sync_q[3:0]};
          `OSS_IDX_CFG1: rdata <= {24'h0, cfg1_q};
          `OSS_IDX_CFG2: rdata <= {24'h0, cfg2_q};
          default: begin
            rdata <= 32'h0;
            rresp <= 2'h2;
          end
        endcase
        if (araddr[1:0] != 2'h0 || araddr[ADDR_W-1:10] != '0) begin
          rresp <= 2'h2;
        end
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // forced reset sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_q     <= 1'b0;
      por_cnt_q <= 16'h0;
    end else if (por_q) begin
      por_cnt_q <= por_cnt_q + 16'h1;
      if (por_cnt_q == 16'(`OSS_POR_CYC - 1)) begin
        por_q <= 1'b0;
      end
    end else if (w_hit && aw_idx_q == `OSS_IDX_SYS && w_byte_q[`OSS_SYS_RESET]) begin
      por_q     <= 1'b1;
      por_cnt_q <= 16'h0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers, kept and writable in power save
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      sys_q  <= `OSS_SYS_RST;
      sync_q <= `OSS_SYNC_RST;
      cfg1_q <= `OSS_CFG1_RST;
      cfg2_q <= `OSS_CFG2_RST;
      swr_q  <= 1'b0;
    end else begin
      // restart bit lives one cycle only
      swr_q <= w_hit && aw_idx_q == `OSS_IDX_SYNC && w_byte_q[`OSS_SYNC_SWR];
      if (w_hit && aw_idx_q == `OSS_IDX_SYS) begin
        sys_q <= w_byte_q & `OSS_SYS_MASK;
      end
      if (w_hit && aw_idx_q == `OSS_IDX_SYNC) begin
        sync_q <= w_byte_q & `OSS_SYNC_MASK;
      end
      if (w_hit && aw_idx_q == `OSS_IDX_CFG1) begin
        cfg1_q <= w_byte_q & `OSS_CFG1_MASK;
      end
      if (w_hit && aw_idx_q == `OSS_IDX_CFG2) begin
        cfg2_q <= w_byte_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample start and abort sources
  // ----------------------------------------------------------------
  // pin triggered modes do not free-run; ticking at or past the period keeps a count that ran on there from stalling
  assign fr_tick = (mode != `OSS_PIN_STRIG) && (mode != `OSS_PIN_XTRIG) && (mode != `OSS_PIN_WAKE)
                   && !psave && (fr_cnt_q >= SMP_PER_CYC - 1);
  assign start = !psave && (swr_q || fr_tick
                 || (fall && !busy && (mode == `OSS_PIN_STRIG || mode == `OSS_PIN_XTRIG))
                 || (fall && !busy && mode == `OSS_PIN_WAKE));
  assign abort = psave || (fall && mode == `OSS_PIN_ABORT);

  // free-run timer, realigned by a sync edge or restart
  always_ff @(posedge aclk) begin
    if (!rst_n || psave || swr_q || fr_tick || (fall && mode == `OSS_PIN_ABORT)) begin
      fr_cnt_q <= 32'h0;
    end else begin
      fr_cnt_q <= fr_cnt_q + 32'h1;
    end
  end

  // pin edge detector; idle pin floats high
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      gpio_prev_q <= 1'b1;
    end else begin
      gpio_prev_q <= gpio_in;
    end
  end

  // exposure length from the pulse width code
  always_comb begin
    case (cfg1_q[1:0])
      2'h0:    pw_cyc = 16'(`OSS_NS2CYC(`OSS_PW0_NS));
      2'h1:    pw_cyc = 16'(`OSS_NS2CYC(`OSS_PW1_NS));
      2'h2:    pw_cyc = 16'(PW2_CYC);
      default: pw_cyc = 16'(PW3_CYC);
    endcase
  end

  oss_seq #(
    .CW (16),
    .XW (3)
  ) u_seq (
    .aclk          (aclk),
    .srst_n        (rst_n),
    .start         (start),
    .abort         (abort),
    .ext_step_mode (mode == `OSS_PIN_XTRIG),
    .step          (fall && mode == `OSS_PIN_XTRIG),
    .n_exp         (3'(NUM_SLOTS)),
    .pw_cyc        (pw_cyc),
    .busy          (busy),
    .exp_done      (exp_done),
    .exp_idx       (exp_idx),
    .smp_done      (smp_done)
  );

  // ----------------------------------------------------------------
  // oscillator, pin driver and flag
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      awake_q  <= 1'b0;
      osc_run  <= 1'b0;
      gpio_oe  <= 1'b0;
      gpio_out <= 1'b0;
      rdy_q    <= 1'b0;
    end else begin
      // one sample per wake edge, then full shutdown
      awake_q  <= (mode == `OSS_PIN_WAKE) && !psave && ((awake_q && !smp_done) || (fall && !busy));
      osc_run  <= !psave && (mode != `OSS_PIN_WAKE || awake_q);
      // reserved codes fall out here with the pin three-stated
      gpio_oe  <= (mode == `OSS_PIN_MUX) && slot_abc_active && !psave;
      gpio_out <= busy;
      // a completion in the read cycle keeps the flag set
      rdy_q    <= smp_done || (rdy_q && !psave && !(ar_take && ar_idx == `OSS_IDX_STAT));
    end
  end

  // ----------------------------------------------------------------
  // data path: dark offset, tags, timestamps
  // ----------------------------------------------------------------
  assign dual = (cfg2_q[7:3] >= `OSS_SR_DUAL_LO) && (cfg2_q[7:3] <= `OSS_SR_DUAL_HI);
  // offset added, saturating rather than wrapping at full scale
  assign sum  = {1'b0, adc_data} + (!cfg1_q[`OSS_CFG1_DOFF] ? 20'h0
                : (dual ? `OSS_OFS_DUAL : `OSS_OFS_SINGLE));
  assign sat  = sum[19] ? `OSS_DATA_MAX : sum[18:0];

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      push_valid <= 1'b0;
      push_tag   <= 5'h00;
      push_data  <= 19'h0;
      ts_pend_q  <= 1'b0;
      smp_cnt_q  <= 3'h0;
      ts_cnt_q   <= 19'h0;
      last_res_q <= 19'h0;
    end else begin
      push_valid <= exp_done || ts_pend_q;
      if (exp_done) begin
        push_data <= sat;
        push_tag  <= (sync_q[`OSS_SYNC_CHG] && dac_code_changed) ? `OSS_TAG_CHG
                     : 5'({2'h0, exp_idx} + 5'h01);
      end else if (ts_pend_q) begin
        push_data <= ts_cnt_q;
        push_tag  <= `OSS_TAG_TS;
      end
      ts_pend_q <= smp_done && sync_q[`OSS_SYNC_TSEN] && (smp_cnt_q == 3'h7);
      if (smp_done) begin
        smp_cnt_q  <= smp_cnt_q + 3'h1;
        ts_cnt_q   <= ts_cnt_q + 19'h1;
        last_res_q <= sat;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int POR_BOUND = `OSS_POR_CYC;
  sequence s_psave_held;
    psave ##1 psave;
  endsequence
  sequence s_sample_end_wake;
    smp_done && mode == `OSS_PIN_WAKE;
  endsequence

  AST_PSAVE_OSC: assert property (@(posedge aclk) disable iff (!rst_n) psave |=> !osc_run)
    else $error("oscillator still running in power save");
  AST_PSAVE_FLAG: assert property (@(posedge aclk) disable iff (!rst_n) s_psave_held |=> !rdy_q)
    else $error("flag not cleared in power save");
  AST_RES_HOLD: assert property (@(posedge aclk) disable iff (!rst_n) s_psave_held |=> $stable(last_res_q))
    else $error("result changed in power save");
  AST_ABORT: assert property (@(posedge aclk) disable iff (!rst_n) psave |=> !busy)
    else $error("conversion not aborted by power save");
  AST_POR_END: assert property (@(posedge aclk) disable iff (!aresetn) $rose(por_q) |-> ##[1:POR_BOUND] !por_q)
    else $error("reset bit did not self-clear");
  AST_POR_REGS: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(por_q) |-> sync_q == `OSS_SYNC_RST && cfg1_q == `OSS_CFG1_RST)
    else $error("registers not at reset value after forced reset");
  AST_TS: assert property (@(posedge aclk) disable iff (!rst_n)
      smp_done && sync_q[`OSS_SYNC_TSEN] && smp_cnt_q == 3'h7 |=> ##1 push_valid && push_tag == `OSS_TAG_TS)
    else $error("timestamp not pushed");
  AST_CHG: assert property (@(posedge aclk) disable iff (!rst_n)
      exp_done && sync_q[`OSS_SYNC_CHG] && dac_code_changed |=> push_tag == 5'h1D)
    else $error("changed code tag missing");
  AST_SWR: assert property (@(posedge aclk) disable iff (!rst_n) swr_q && !psave |=> !swr_q && busy)
    else $error("restart bit not self-cleared or sample not started");
  AST_TRISTATE: assert property (@(posedge aclk) disable iff (!rst_n) mode != `OSS_PIN_MUX |=> !gpio_oe)
    else $error("pin driven outside mux mode");
  AST_HWABORT: assert property (@(posedge aclk) disable iff (!rst_n)
      fall && mode == `OSS_PIN_ABORT && !swr_q && !fr_tick |=> !busy)
    else $error("falling edge did not terminate sample");
  AST_WAKE_OFF: assert property (@(posedge aclk) disable iff (!rst_n) s_sample_end_wake |=> ##1 !osc_run)
    else $error("device not shut down after single sample");
  AST_OFFSET: assert property (@(posedge aclk) disable iff (!rst_n)
      exp_done && cfg1_q[`OSS_CFG1_DOFF] && !dual && adc_data < 19'h7E000 |=> push_data == $past(adc_data) + 19'h02000)
    else $error("single pulse dark offset wrong");
endmodule
`default_nettype wire

// ### verification/oss_far_model.sv
// far side model: idle trigger pin and converter result feed
`timescale 1ns/100ps
`default_nettype none
module oss_far_model (
  input  wire logic        pin_i,
  input  wire logic        chg_i,
  input  wire logic        abc_i,
  output logic             gpio_in,
  output logic [18:0]      adc_data,
  output logic             dac_code_changed,
  output logic             slot_abc_active
);
  // pin has a pull-up; the bench pulses it low as a paired controller set up like this device, after it
  assign gpio_in          = pin_i;
  // small fixed result so an added offset is easy to see
  assign adc_data         = 19'h00100;
  assign dac_code_changed = chg_i;
  assign slot_abc_active  = abc_i;
endmodule
`default_nettype wire

// ### verification/optical_sample_sync_control_bench.sv
// self-checking bench for the sample sync control block
`timescale 1ns/100ps
`default_nettype none
module optical_sample_sync_control_bench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        aclk = 1'b0, aresetn = 1'b0, chg = 1'b0, abc = 1'b0, pin = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, rd_q;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, resp_q;
  logic        awready, wready, bvalid, arready, rvalid, gpio_in, gpio_out, gpio_oe;
  logic        slot_abc_active, dac_code_changed, osc_run, push_valid, hit;
  logic [18:0] adc_data, push_data;
  logic [4:0]  push_tag;
  int          errors = 0, cmp_count = 0;
  // short counts keep the free-running sample period at 50 cycles
  oss_top #(.SMP_PER_CYC(50), .PW2_CYC(4), .PW3_CYC(4)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .gpio_in, .gpio_out, .gpio_oe, .slot_abc_active, .adc_data, .dac_code_changed, .osc_run,
    .push_valid, .push_tag, .push_data);
  oss_far_model far (.pin_i(pin), .chg_i(chg), .abc_i(abc), .gpio_in, .adc_data, .dac_code_changed,
    .slot_abc_active);
  always #4 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // write one register word; each channel is dropped at its own handshake
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    resp_q = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask
  // watch the push stream for one tag within a bounded number of cycles
  task automatic wait_tag(input logic [4:0] tag, input int n);
    hit = 1'b0;
    repeat (n) begin
      @(posedge aclk);
      if (push_valid === 1'b1 && push_tag === tag) hit = 1'b1;
      if (hit) break;
    end
  endtask
  task automatic t_power_save();
    wr(8'h0D, 8'h02);
    check(resp_q, 2'h0);
    wr(8'h11, 8'h4F);
    rd(8'h11);
    check(rd_q, 32'h0000004F);
    check(osc_run, 1'b0);
    wr(8'h0D, 8'h00);
    wr(8'h11, 8'h03);
  endtask
  task automatic t_forced_reset();
    wr(8'h10, 8'hC2);
    wr(8'h0D, 8'h01);
    rd(8'h0D);
    check(rd_q[0], 1'b1);
    repeat (200) begin
      rd(8'h0D);
      if (rd_q[0] === 1'b0) break;
    end
    check(rd_q[0], 1'b0);
    rd(8'h10);
    check(rd_q, 32'h00000000);
    rd(8'h11);
    check(rd_q, 32'h00000003);
  endtask
  task automatic t_tags();
    wr(8'h10, 8'h10);
    rd(8'h10);
    check(rd_q, 32'h00000000);
    wr(8'h10, 8'h40);
    chg <= 1'b1;
    wait_tag(5'h1D, 300);
    check(hit, 1'b1);
    chg <= 1'b0;
    wait_tag(5'h01, 300);
    check(hit, 1'b1);
    wr(8'h10, 8'h80);
    wait_tag(5'h1E, 1000);
    check(hit, 1'b1);
    wr(8'h10, 8'h00);
    wait_tag(5'h1E, 1000);
    check(hit, 1'b0);
    wr(8'h11, 8'h43);
    wait_tag(5'h01, 300);
    check(push_data, 19'h02100);
  endtask
  task automatic t_pin();
    abc <= 1'b1;
    repeat (4) @(posedge aclk);
    check(gpio_oe, 1'b1);
    wr(8'h10, 8'h05);
    repeat (3) @(posedge aclk);
    check(gpio_oe, 1'b0);
    rd(8'h3F);
    check(resp_q, 2'h2);
  endtask
  // pin modes: sample trigger, sync abort, single sample wake
  task automatic t_trigger();
    wr(8'h10, 8'h02);
    repeat (20) @(posedge aclk);
    pin <= 1'b0;
    repeat (3) @(posedge aclk);
    check(gpio_out, 1'b1);
    wait_tag(5'h01, 20);
    check(hit, 1'b1);
    pin <= 1'b1;
    wait_tag(5'h01, 120);
    check(hit, 1'b0);
    wr(8'h10, 8'h19);
    pin <= 1'b0;
    wait_tag(5'h01, 30);
    check(hit, 1'b0);
    pin <= 1'b1;
    wr(8'h10, 8'h0A);
    repeat (2) @(posedge aclk);
    check(osc_run, 1'b0);
    wr(8'h10, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_power_save();
    t_forced_reset();
    t_tags();
    t_trigger();
    t_pin();
    give_verdict();
  end
  // the whole run needs a few thousand cycles; this cuts a hang short
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
